// File: design/lsw_core.sv
// Core for the register/memory and 16-bit instruction groups.
// Assumes one byte-wide memory port; read data is valid in the cycle the
// address is driven. Other instruction groups are left to other logic.
`timescale 1ns/1ps
module lsw_core (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Memory port
	input wire logic [7:0] mem_rdata_i,
	output logic [15:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [7:0] mem_wdata_o,
	// Register view
	output logic [7:0] acc_o,
	output logic [7:0] xreg_o,
	output logic [7:0] yreg_o,
	output logic [7:0] sp_o,
	output logic [7:0] psw_o,
	output logic [15:0] pc_o,
	// Instruction events
	output logic instr_done_o,
	output logic unsup_op_o
);
	lsw_pkg::lsw_st_t s_r; // Registered state
	lsw_pkg::lsw_st_t s_nxt; // Next state
	lsw_pkg::lsw_dec_t dec_w; // Decode of the byte on the bus
	logic [15:0] alu_a; // Word ALU operand A
	logic [15:0] alu_b; // Word ALU operand B
	logic alu_sub; // Word ALU subtract select
	logic [15:0] alu_res; // Word ALU result
	logic alu_n, alu_v, alu_h, alu_z, alu_c; // Word ALU flags

	// Opcode table: class, addressing mode, total cycles
	function automatic lsw_pkg::lsw_dec_t dec_op(input logic [7:0] op);
		lsw_pkg::lsw_dec_t d;
		d = '{lsw_pkg::CL_NONE, lsw_pkg::AM_IMP, lsw_pkg::NOP_LEN};
		case (op)
			8'hC4: d = '{lsw_pkg::CL_ACC_LOAD, lsw_pkg::AM_IMM, 4'h2};
			8'hC5: d = '{lsw_pkg::CL_ACC_LOAD, lsw_pkg::AM_DP, 4'h3};
			8'hC6: d = '{lsw_pkg::CL_ACC_LOAD, lsw_pkg::AM_DPX, 4'h4};
			8'hC7: d = '{lsw_pkg::CL_ACC_LOAD, lsw_pkg::AM_ABS, 4'h4};
			8'hD5: d = '{lsw_pkg::CL_ACC_LOAD, lsw_pkg::AM_ABSY, 4'h5};
			8'hD6: d = '{lsw_pkg::CL_ACC_LOAD, lsw_pkg::AM_IDXIND, 4'h6};
			8'hD7: d = '{lsw_pkg::CL_ACC_LOAD, lsw_pkg::AM_INDIDX, 4'h6};
			8'hD4: d = '{lsw_pkg::CL_ACC_LOAD, lsw_pkg::AM_XPTR, 4'h3};
			8'hDB: d = '{lsw_pkg::CL_ACC_LOAD, lsw_pkg::AM_XPINC, 4'h4};
			8'hE4: d = '{lsw_pkg::CL_MEM_IMM, lsw_pkg::AM_DPIMM, 4'h5};
			8'h1E: d = '{lsw_pkg::CL_X_LOAD, lsw_pkg::AM_IMM, 4'h2};
			8'hCC: d = '{lsw_pkg::CL_X_LOAD, lsw_pkg::AM_DP, 4'h3};
			8'hCD: d = '{lsw_pkg::CL_X_LOAD, lsw_pkg::AM_DPY, 4'h4};
			8'hDC: d = '{lsw_pkg::CL_X_LOAD, lsw_pkg::AM_ABS, 4'h4};
			8'h3E: d = '{lsw_pkg::CL_Y_LOAD, lsw_pkg::AM_IMM, 4'h2};
			8'hC9: d = '{lsw_pkg::CL_Y_LOAD, lsw_pkg::AM_DP, 4'h3};
			8'hD9: d = '{lsw_pkg::CL_Y_LOAD, lsw_pkg::AM_DPX, 4'h4};
			8'hD8: d = '{lsw_pkg::CL_Y_LOAD, lsw_pkg::AM_ABS, 4'h4};
			8'hE5: d = '{lsw_pkg::CL_ACC_STORE, lsw_pkg::AM_DP, 4'h4};
			8'hE6: d = '{lsw_pkg::CL_ACC_STORE, lsw_pkg::AM_DPX, 4'h5};
			8'hE7: d = '{lsw_pkg::CL_ACC_STORE, lsw_pkg::AM_ABS, 4'h5};
			8'hF5: d = '{lsw_pkg::CL_ACC_STORE, lsw_pkg::AM_ABSY, 4'h6};
			8'hF6: d = '{lsw_pkg::CL_ACC_STORE, lsw_pkg::AM_IDXIND, 4'h7};
			8'hF7: d = '{lsw_pkg::CL_ACC_STORE, lsw_pkg::AM_INDIDX, 4'h7};
			8'hF4: d = '{lsw_pkg::CL_ACC_STORE, lsw_pkg::AM_XPTR, 4'h4};
			8'hFB: d = '{lsw_pkg::CL_ACC_STORE, lsw_pkg::AM_XPINC, 4'h4};
			8'hEC: d = '{lsw_pkg::CL_X_STORE, lsw_pkg::AM_DP, 4'h4};
			8'hED: d = '{lsw_pkg::CL_X_STORE, lsw_pkg::AM_DPY, 4'h5};
			8'hFC: d = '{lsw_pkg::CL_X_STORE, lsw_pkg::AM_ABS, 4'h5};
			8'hE9: d = '{lsw_pkg::CL_Y_STORE, lsw_pkg::AM_DP, 4'h4};
			8'hF9: d = '{lsw_pkg::CL_Y_STORE, lsw_pkg::AM_DPX, 4'h5};
			8'hF8: d = '{lsw_pkg::CL_Y_STORE, lsw_pkg::AM_ABS, 4'h5};
			8'hE8: d = '{lsw_pkg::CL_A2X, lsw_pkg::AM_IMP, 4'h2};
			8'h9F: d = '{lsw_pkg::CL_A2Y, lsw_pkg::AM_IMP, 4'h2};
			8'hAE: d = '{lsw_pkg::CL_SP2X, lsw_pkg::AM_IMP, 4'h2};
			8'hC8: d = '{lsw_pkg::CL_X2A, lsw_pkg::AM_IMP, 4'h2};
			8'h8E: d = '{lsw_pkg::CL_X2SP, lsw_pkg::AM_IMP, 4'h2};
			8'hBF: d = '{lsw_pkg::CL_Y2A, lsw_pkg::AM_IMP, 4'h2};
			8'hEE: d = '{lsw_pkg::CL_SWAP_AX, lsw_pkg::AM_IMP, 4'h4};
			8'hDE: d = '{lsw_pkg::CL_SWAP_AY, lsw_pkg::AM_IMP, 4'h4};
			8'hBC: d = '{lsw_pkg::CL_SWAP_MA, lsw_pkg::AM_DP, 4'h5};
			8'hAD: d = '{lsw_pkg::CL_SWAP_MA, lsw_pkg::AM_DPX, 4'h6};
			8'hBB: d = '{lsw_pkg::CL_SWAP_MA, lsw_pkg::AM_XPTR, 4'h5};
			8'hFE: d = '{lsw_pkg::CL_SWAP_XY, lsw_pkg::AM_IMP, 4'h4};
			8'h1D: d = '{lsw_pkg::CL_W_ADD, lsw_pkg::AM_DP, 4'h5};
			8'h3D: d = '{lsw_pkg::CL_W_SUB, lsw_pkg::AM_DP, 4'h5};
			8'h5D: d = '{lsw_pkg::CL_W_CMP, lsw_pkg::AM_DP, 4'h4};
			8'hBD: d = '{lsw_pkg::CL_W_DEC, lsw_pkg::AM_DP, 4'h6};
			8'h9D: d = '{lsw_pkg::CL_W_INC, lsw_pkg::AM_DP, 4'h6};
			8'h7D: d = '{lsw_pkg::CL_W_LOAD, lsw_pkg::AM_DP, 4'h5};
			8'hDD: d = '{lsw_pkg::CL_W_STORE, lsw_pkg::AM_DP, 4'h5};
			default: d = '{lsw_pkg::CL_NONE, lsw_pkg::AM_IMP, lsw_pkg::NOP_LEN};
		endcase
		return d;
	endfunction : dec_op

	// True for classes whose memory step is a write
	function automatic logic is_store(input lsw_pkg::lsw_cls_t c);
		return c inside {lsw_pkg::CL_ACC_STORE, lsw_pkg::CL_X_STORE,
			lsw_pkg::CL_Y_STORE, lsw_pkg::CL_MEM_IMM, lsw_pkg::CL_W_STORE};
	endfunction : is_store

	// Direct-page address; the G flag picks page 0 or page 1
	function automatic logic [15:0] dp_addr(input logic g,
		input logic [7:0] off);
		return {7'h00, g, off};
	endfunction : dp_addr

	// Set N and Z from a byte
	function automatic logic [7:0] set_nz(input logic [7:0] p,
		input logic [7:0] v);
		logic [7:0] q;
		q = p;
		q[lsw_pkg::PSW_N] = v[7];
		q[lsw_pkg::PSW_Z] = (v == 8'h00);
		return q;
	endfunction : set_nz

	assign dec_w = dec_op(mem_rdata_i);

	// Word ALU inputs; increment and decrement work on the memory word
	always_comb begin
		if (s_r.d.cls inside {lsw_pkg::CL_W_INC, lsw_pkg::CL_W_DEC}) begin
			alu_a = {mem_rdata_i, s_r.tmp};
			alu_b = 16'h0001;
		end else begin
			alu_a = {s_r.y, s_r.a};
			alu_b = {mem_rdata_i, s_r.tmp};
		end
		alu_sub = s_r.d.cls inside {lsw_pkg::CL_W_SUB, lsw_pkg::CL_W_CMP,
			lsw_pkg::CL_W_DEC};
	end

	lsw_word_alu u_alu (
		.opa_i(alu_a),
		.opb_i(alu_b),
		.sub_i(alu_sub),
		.res_o(alu_res),
		.n_o(alu_n),
		.v_o(alu_v),
		.h_o(alu_h),
		.z_o(alu_z),
		.c_o(alu_c)
	);

	// Sequencer: one memory access a cycle, then pad to the cycle count
	always_comb begin
		logic fin; // Work done, pad or fetch
		logic go_mem; // Operand address known
		logic do_ld; // Byte load into A, X or Y
		logic [7:0] ld_v; // Byte to load
		logic g; // Direct-page select
		fin = 1'b0;
		go_mem = 1'b0;
		do_ld = 1'b0;
		ld_v = mem_rdata_i;
		g = s_r.psw[lsw_pkg::PSW_G];
		s_nxt = s_r;
		s_nxt.cnt = s_r.cnt + 4'h1;
		s_nxt.done = 1'b0;
		s_nxt.unsup = 1'b0;
		case (s_r.st)
			lsw_pkg::ST_FETCH: begin
				s_nxt.d = dec_w;
				s_nxt.pc = s_r.pc + 16'h0001;
				s_nxt.unsup = (dec_w.cls == lsw_pkg::CL_NONE);
				if (dec_w.mode == lsw_pkg::AM_IMP) begin
					fin = 1'b1;
					// Register transfers finish at once; the rest is padding
					case (dec_w.cls)
						lsw_pkg::CL_A2X: begin
							s_nxt.x = s_r.a;
							s_nxt.psw = set_nz(s_r.psw, s_r.a);
						end
						lsw_pkg::CL_A2Y: begin
							s_nxt.y = s_r.a;
							s_nxt.psw = set_nz(s_r.psw, s_r.a);
						end
						lsw_pkg::CL_SP2X: begin
							s_nxt.x = s_r.sp;
							s_nxt.psw = set_nz(s_r.psw, s_r.sp);
						end
						lsw_pkg::CL_X2A: begin
							s_nxt.a = s_r.x;
							s_nxt.psw = set_nz(s_r.psw, s_r.x);
						end
						lsw_pkg::CL_X2SP: begin
							s_nxt.sp = s_r.x;
							s_nxt.psw = set_nz(s_r.psw, s_r.x);
						end
						lsw_pkg::CL_Y2A: begin
							s_nxt.a = s_r.y;
							s_nxt.psw = set_nz(s_r.psw, s_r.y);
						end
						lsw_pkg::CL_SWAP_AX: begin
							s_nxt.a = s_r.x;
							s_nxt.x = s_r.a;
						end
						lsw_pkg::CL_SWAP_AY: begin
							s_nxt.a = s_r.y;
							s_nxt.y = s_r.a;
						end
						lsw_pkg::CL_SWAP_XY: begin
							s_nxt.x = s_r.y;
							s_nxt.y = s_r.x;
						end
						default: fin = 1'b1; // Unknown opcode: plain padding
					endcase
				end else if (dec_w.mode inside {lsw_pkg::AM_XPTR,
					lsw_pkg::AM_XPINC}) begin
					s_nxt.ea = dp_addr(g, s_r.x);
					go_mem = 1'b1;
				end else begin
					s_nxt.st = lsw_pkg::ST_OP1;
				end
			end
			lsw_pkg::ST_OP1: begin
				s_nxt.pc = s_r.pc + 16'h0001;
				s_nxt.dpb = mem_rdata_i;
				case (s_r.d.mode)
					lsw_pkg::AM_IMM: begin
						do_ld = 1'b1;
						fin = 1'b1;
					end
					lsw_pkg::AM_DP: begin
						s_nxt.ea = dp_addr(g, mem_rdata_i);
						go_mem = 1'b1;
					end
					lsw_pkg::AM_DPX: begin
						s_nxt.dpb = 8'(mem_rdata_i + s_r.x);
						s_nxt.ea = dp_addr(g, 8'(mem_rdata_i + s_r.x));
						go_mem = 1'b1;
					end
					lsw_pkg::AM_DPY: begin
						s_nxt.dpb = 8'(mem_rdata_i + s_r.y);
						s_nxt.ea = dp_addr(g, 8'(mem_rdata_i + s_r.y));
						go_mem = 1'b1;
					end
					lsw_pkg::AM_IDXIND: begin
						s_nxt.ea = dp_addr(g, 8'(mem_rdata_i + s_r.x));
						s_nxt.st = lsw_pkg::ST_PLO;
					end
					lsw_pkg::AM_INDIDX: begin
						s_nxt.ea = dp_addr(g, mem_rdata_i);
						s_nxt.st = lsw_pkg::ST_PLO;
					end
					default: begin
						// Absolute forms and the immediate-to-memory load
						s_nxt.tmp = mem_rdata_i;
						s_nxt.st = lsw_pkg::ST_OP2;
					end
				endcase
			end
			lsw_pkg::ST_OP2: begin
				s_nxt.pc = s_r.pc + 16'h0001;
				if (s_r.d.mode == lsw_pkg::AM_DPIMM) begin
					s_nxt.tmp = mem_rdata_i;
					s_nxt.ea = dp_addr(g, s_r.dpb);
				end else if (s_r.d.mode == lsw_pkg::AM_ABSY) begin
					s_nxt.ea = {mem_rdata_i, s_r.tmp} + {8'h00, s_r.y};
				end else begin
					s_nxt.ea = {mem_rdata_i, s_r.tmp};
				end
				go_mem = 1'b1;
			end
			lsw_pkg::ST_PLO: begin
				// Pointer bytes stay inside the direct page
				s_nxt.tmp = mem_rdata_i;
				s_nxt.ea = dp_addr(g, 8'(s_r.ea[7:0] + 8'h01));
				s_nxt.st = lsw_pkg::ST_PHI;
			end
			lsw_pkg::ST_PHI: begin
				if (s_r.d.mode == lsw_pkg::AM_INDIDX) begin
					s_nxt.ea = {mem_rdata_i, s_r.tmp} + {8'h00, s_r.y};
				end else begin
					s_nxt.ea = {mem_rdata_i, s_r.tmp};
				end
				go_mem = 1'b1;
			end
			lsw_pkg::ST_MEM: begin
				if (s_r.d.mode == lsw_pkg::AM_XPINC) begin
					s_nxt.x = s_r.x + 8'h01;
				end
				case (s_r.d.cls)
					lsw_pkg::CL_ACC_LOAD, lsw_pkg::CL_X_LOAD,
					lsw_pkg::CL_Y_LOAD: begin
						do_ld = 1'b1;
						fin = 1'b1;
					end
					lsw_pkg::CL_SWAP_MA: begin
						// Old accumulator goes back to the same address
						s_nxt.a = mem_rdata_i;
						s_nxt.psw = set_nz(s_r.psw, mem_rdata_i);
						s_nxt.wdata = s_r.a;
						s_nxt.st = lsw_pkg::ST_WR;
					end
					lsw_pkg::CL_W_STORE: begin
						s_nxt.ea = dp_addr(g, 8'(s_r.dpb + 8'h01));
						s_nxt.wdata = s_r.y;
						s_nxt.st = lsw_pkg::ST_WR2;
					end
					lsw_pkg::CL_W_ADD, lsw_pkg::CL_W_SUB, lsw_pkg::CL_W_CMP,
					lsw_pkg::CL_W_INC, lsw_pkg::CL_W_DEC,
					lsw_pkg::CL_W_LOAD: begin
						s_nxt.tmp = mem_rdata_i; // Low byte of the pair
						s_nxt.ea = dp_addr(g, 8'(s_r.dpb + 8'h01));
						s_nxt.st = lsw_pkg::ST_MHI;
					end
					default: fin = 1'b1; // Store written, flags untouched
				endcase
			end
			lsw_pkg::ST_MHI: begin
				fin = 1'b1;
				case (s_r.d.cls)
					lsw_pkg::CL_W_LOAD: begin
						s_nxt.a = s_r.tmp;
						s_nxt.y = mem_rdata_i;
						s_nxt.psw[lsw_pkg::PSW_N] = mem_rdata_i[7];
						s_nxt.psw[lsw_pkg::PSW_Z] =
							({mem_rdata_i, s_r.tmp} == 16'h0000);
					end
					lsw_pkg::CL_W_ADD, lsw_pkg::CL_W_SUB: begin
						{s_nxt.y, s_nxt.a} = alu_res;
						s_nxt.psw[lsw_pkg::PSW_N] = alu_n;
						s_nxt.psw[lsw_pkg::PSW_V] = alu_v;
						s_nxt.psw[lsw_pkg::PSW_H] = alu_h;
						s_nxt.psw[lsw_pkg::PSW_Z] = alu_z;
						s_nxt.psw[lsw_pkg::PSW_C] = alu_c;
					end
					lsw_pkg::CL_W_CMP: begin
						s_nxt.psw[lsw_pkg::PSW_N] = alu_n;
						s_nxt.psw[lsw_pkg::PSW_Z] = alu_z;
						s_nxt.psw[lsw_pkg::PSW_C] = alu_c;
					end
					default: begin
						// Increment or decrement: write low, then high
						fin = 1'b0;
						s_nxt.psw[lsw_pkg::PSW_N] = alu_n;
						s_nxt.psw[lsw_pkg::PSW_Z] = alu_z;
						s_nxt.wdata = alu_res[7:0];
						s_nxt.tmp = alu_res[15:8];
						s_nxt.ea = dp_addr(g, s_r.dpb);
						s_nxt.st = lsw_pkg::ST_WR;
					end
				endcase
			end
			lsw_pkg::ST_WR: begin
				if (s_r.d.cls inside {lsw_pkg::CL_W_INC, lsw_pkg::CL_W_DEC}) begin
					s_nxt.ea = dp_addr(g, 8'(s_r.dpb + 8'h01));
					s_nxt.wdata = s_r.tmp;
					s_nxt.st = lsw_pkg::ST_WR2;
				end else begin
					fin = 1'b1;
				end
			end
			default: fin = 1'b1; // Second write, waiting
		endcase
		// Byte loads share one path; only NZ change
		if (do_ld) begin
			s_nxt.psw = set_nz(s_r.psw, ld_v);
			case (s_r.d.cls)
				lsw_pkg::CL_X_LOAD: s_nxt.x = ld_v;
				lsw_pkg::CL_Y_LOAD: s_nxt.y = ld_v;
				default: s_nxt.a = ld_v;
			endcase
		end
		// Operand step: stores write now, everything else reads
		if (go_mem) begin
			s_nxt.st = lsw_pkg::ST_MEM;
			case (s_r.d.cls)
				lsw_pkg::CL_X_STORE: s_nxt.wdata = s_r.x;
				lsw_pkg::CL_Y_STORE: s_nxt.wdata = s_r.y;
				lsw_pkg::CL_MEM_IMM: s_nxt.wdata = s_nxt.tmp;
				default: s_nxt.wdata = s_r.a;
			endcase
		end
		// Pad to the documented count; fetch is cycle zero
		if (fin) begin
			if ({1'b0, s_r.cnt} + 5'h01 >= {1'b0, s_nxt.d.len}) begin
				s_nxt.st = lsw_pkg::ST_FETCH;
				s_nxt.cnt = 4'h0;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.st = lsw_pkg::ST_WAIT;
			end
		end
		// Bus controls follow the step being entered
		s_nxt.wr = (s_nxt.st inside {lsw_pkg::ST_WR, lsw_pkg::ST_WR2}) ||
			(s_nxt.st == lsw_pkg::ST_MEM && is_store(s_nxt.d.cls));
		s_nxt.rd = !s_nxt.wr && (s_nxt.st != lsw_pkg::ST_WAIT);
		s_nxt.addr = (s_nxt.st inside {lsw_pkg::ST_FETCH, lsw_pkg::ST_OP1,
			lsw_pkg::ST_OP2}) ? s_nxt.pc : s_nxt.ea;
	end

	// State register
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= lsw_pkg::RST_ST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign mem_addr_o = s_r.addr;
	assign mem_rd_o = s_r.rd;
	assign mem_wr_o = s_r.wr;
	assign mem_wdata_o = s_r.wdata;
	assign acc_o = s_r.a;
	assign xreg_o = s_r.x;
	assign yreg_o = s_r.y;
	assign sp_o = s_r.sp;
	assign psw_o = s_r.psw;
	assign pc_o = s_r.pc;
	assign instr_done_o = s_r.done;
	assign unsup_op_o = s_r.unsup;

	// Checks on instruction timing and effects
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence sq_fetch;
		s_r.st == lsw_pkg::ST_FETCH;
	endsequence
	sequence sq_fetch_at(logic [7:0] op);
		s_r.st == lsw_pkg::ST_FETCH && mem_rdata_i == op;
	endsequence

	a_acc_imm_load: assert property (
		sq_fetch_at(8'hC4) |-> ##2 (sq_fetch and s_r.a == $past(mem_rdata_i)))
		else $error("immediate accumulator load wrong");
	a_mem_imm_write: assert property (
		sq_fetch_at(8'hE4) |-> ##3 (mem_wr_o &&
		mem_wdata_o == $past(mem_rdata_i)) ##2 sq_fetch)
		else $error("immediate memory load wrong");
	a_acc_store_flags: assert property (
		(mem_wr_o && s_r.st == lsw_pkg::ST_MEM &&
		s_r.d.cls == lsw_pkg::CL_ACC_STORE) |->
		(mem_wdata_o == s_r.a) ##1 $stable(s_r.psw))
		else $error("accumulator store data or flags wrong");
	a_store_post_inc: assert property (
		sq_fetch_at(8'hFB) |-> ##1 (mem_wr_o &&
		mem_addr_o[7:0] == $past(s_r.x)) ##3
		(sq_fetch and s_r.x == 8'($past(s_r.x, 4) + 8'h01)))
		else $error("post-increment store wrong");
	a_copy_acc_x: assert property (
		sq_fetch_at(8'hE8) |=> (s_r.x == $past(s_r.a) &&
		s_r.psw[lsw_pkg::PSW_Z] == (s_r.x == 8'h00)) ##1 sq_fetch)
		else $error("accumulator to X copy wrong");
	a_swap_x_y: assert property (
		sq_fetch_at(8'hFE) |-> ##4 (sq_fetch and
		s_r.x == $past(s_r.y, 4) && s_r.y == $past(s_r.x, 4) &&
		s_r.psw == $past(s_r.psw, 4)))
		else $error("X and Y swap wrong");
	a_word_cmp_keep: assert property (
		sq_fetch_at(8'h5D) |-> (!mem_wr_o)[*4] ##0
		1'b1 ##1 (sq_fetch and {s_r.y, s_r.a} == $past({s_r.y, s_r.a}, 4)))
		else $error("word compare changed state");
	a_word_inc_len: assert property (
		sq_fetch_at(8'h9D) |-> ##4 mem_wr_o[*2] ##1 sq_fetch)
		else $error("word increment timing wrong");

endmodule : lsw_core

// File: design/lsw_pkg.sv
// Shared types and constants for the load, store, transfer and word core.
// Assumes a byte-wide memory that answers a read in the cycle it is asked.
package lsw_pkg;

	// Status word bit positions (N V G B H I Z C, bit 7 down to 0)
	localparam int PSW_N = 7;
	localparam int PSW_V = 6;
	localparam int PSW_G = 5;
	localparam int PSW_H = 3;
	localparam int PSW_Z = 1;
	localparam int PSW_C = 0;

	// Reset values
	localparam logic [15:0] RST_PC = 16'h0000;
	localparam logic [7:0] RST_SP = 8'hFF;
	localparam logic [7:0] RST_PSW = 8'h00;

	// Cycle count given to opcodes outside this block's groups
	localparam logic [3:0] NOP_LEN = 4'h2;

	// Sequencer steps
	typedef enum logic [3:0] {
		ST_FETCH, ST_OP1, ST_OP2, ST_PLO, ST_PHI,
		ST_MEM, ST_MHI, ST_WR, ST_WR2, ST_WAIT
	} lsw_state_t;

	// Instruction classes
	typedef enum logic [4:0] {
		CL_NONE, CL_ACC_LOAD, CL_X_LOAD, CL_Y_LOAD,
		CL_ACC_STORE, CL_X_STORE, CL_Y_STORE, CL_MEM_IMM,
		CL_A2X, CL_A2Y, CL_SP2X, CL_X2A, CL_X2SP, CL_Y2A,
		CL_SWAP_AX, CL_SWAP_AY, CL_SWAP_MA, CL_SWAP_XY,
		CL_W_ADD, CL_W_SUB, CL_W_CMP, CL_W_INC, CL_W_DEC,
		CL_W_LOAD, CL_W_STORE
	} lsw_cls_t;

	// Addressing modes
	typedef enum logic [3:0] {
		AM_IMP, AM_IMM, AM_DP, AM_DPX, AM_DPY, AM_ABS, AM_ABSY,
		AM_IDXIND, AM_INDIDX, AM_XPTR, AM_XPINC, AM_DPIMM
	} lsw_mode_t;

	// Decoded opcode
	typedef struct packed {
		lsw_cls_t cls;
		lsw_mode_t mode;
		logic [3:0] len;
	} lsw_dec_t;

	// Whole state of the core
	typedef struct packed {
		lsw_state_t st;
		logic [3:0] cnt;
		lsw_dec_t d;
		logic [15:0] pc;
		logic [7:0] a;
		logic [7:0] x;
		logic [7:0] y;
		logic [7:0] sp;
		logic [7:0] psw;
		logic [15:0] ea;
		logic [7:0] dpb;
		logic [7:0] tmp;
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
		logic done;
		logic unsup;
	} lsw_st_t;

	localparam lsw_st_t RST_ST = '{st: ST_FETCH, cnt: 4'h0,
		d: '{cls: CL_NONE, mode: AM_IMP, len: 4'h0},
		pc: RST_PC, a: 8'h00, x: 8'h00, y: 8'h00, sp: RST_SP,
		psw: RST_PSW, ea: 16'h0000, dpb: 8'h00, tmp: 8'h00,
		addr: RST_PC, rd: 1'b1, wr: 1'b0, wdata: 8'h00,
		done: 1'b0, unsup: 1'b0};

endpackage : lsw_pkg

// File: design/lsw_word_alu.sv
// Sixteen-bit adder and subtractor for the word operations.
// Purely combinational; the caller registers the outputs it uses and drops the result of a compare.
`timescale 1ns/1ps
module lsw_word_alu (
	// Operands
	input wire logic [15:0] opa_i,
	input wire logic [15:0] opb_i,
	input wire logic sub_i,
	// Result and flags
	output logic [15:0] res_o,
	output logic n_o,
	output logic v_o,
	output logic h_o,
	output logic z_o,
	output logic c_o
);
	logic [15:0] b; // Operand B, inverted for subtract
	logic [16:0] sum; // Full sum with carry out
	logic [12:0] low; // Low twelve bits, for the half carry

	// Subtract is A + ~B + 1, so C reads as "no borrow"
	always_comb begin
		b = sub_i ? ~opb_i : opb_i;
		sum = {1'b0, opa_i} + {1'b0, b} + {16'h0000, sub_i};
		low = {1'b0, opa_i[11:0]} + {1'b0, b[11:0]} + {12'h000, sub_i};
		res_o = sum[15:0];
		c_o = sum[16];
		h_o = low[12]; // Carry out of bit 11 of the word
		n_o = sum[15];
		z_o = (sum[15:0] == 16'h0000);
		v_o = (opa_i[15] == b[15]) && (sum[15] != opa_i[15]);
	end

endmodule : lsw_word_alu

// File: testbench/lsw_mem_model.sv
// Byte-wide memory standing at the core's memory port.
// Assumes one clock; read data follows the address in the same cycle.
`timescale 1ns/1ps
module lsw_mem_model (
	// Clock
	input wire logic clk_sys_i,
	// Memory port seen from the core
	input wire logic [15:0] mem_addr_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic [7:0] mem_wdata_i,
	output logic [7:0] mem_rdata_o
);
	// Storage, loaded by the bench through a hierarchical path
	logic [7:0] mem [0:65535];
	// Last byte handed out
	logic [7:0] last_r = 8'h00;

	// Idle bus shows the inverse of the last read, so a core that
	// samples outside a read cycle cannot pick up a lucky match
	assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last_r;

	// Write on the edge that ends a write cycle; remember each read
	always @(posedge clk_sys_i) begin
		if (mem_wr_i) begin
			mem[mem_addr_i] <= mem_wdata_i;
		end
		if (mem_rd_i) begin
			last_r <= mem[mem_addr_i];
		end
	end
endmodule : lsw_mem_model

// File: testbench/test_load_store_transfer_word_ops.sv
// Bench: a reference interpreter runs the same program image and is
// compared with the core at every instruction boundary.
// Assumes lsw_mem_model answers reads in the cycle they are made.
`timescale 1ns/1ps
module test_load_store_transfer_word_ops;
	// Opcode, operand kind, byte length, cycle count
	localparam logic [19:0] PROG [0:47] = '{
		20'hC4122, 20'hE8012, 20'h9F012, 20'hAE012, 20'hC8012,
		20'h8E012, 20'hBF012, 20'h1E222, 20'h3E222, 20'hDB014,
		20'hFB014, 20'hBB015, 20'hED425, 20'hF9425, 20'hAD426,
		20'hE6425, 20'hF5536, 20'hC5323, 20'hD5535, 20'hD4013,
		20'hE5324, 20'hEC324, 20'hE9324, 20'hFC535, 20'hF8535,
		20'hE4635, 20'hBC325, 20'hF7727, 20'h7D325, 20'h1D325,
		20'h3D325, 20'h5D324, 20'h9D326, 20'hBD326, 20'hC4822,
		20'h9F012, 20'hDD925, 20'h9D926, 20'hBD926, 20'hDD925,
		20'h5D924, 20'hEE014, 20'hDE014, 20'hFE014, 20'hCD424,
		20'hC9323, 20'hDC534, 20'h00012};
	// Core ports
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] rdata, wdata, acc, xr, yr, spr, psw;
	logic [15:0] addr, pcv;
	logic rd, wr, done, unsup;
	// Reference machine
	logic [7:0] m [0:65535];
	logic [7:0] a, x, y, sp, f, b1, b2, e;
	logic [15:0] pc, w, ya;
	logic [16:0] r;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;

	lsw_core dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.mem_rdata_i(rdata), .mem_addr_o(addr), .mem_rd_o(rd),
		.mem_wr_o(wr), .mem_wdata_o(wdata), .acc_o(acc), .xreg_o(xr),
		.yreg_o(yr), .sp_o(spr), .psw_o(psw), .pc_o(pcv),
		.instr_done_o(done), .unsup_op_o(unsup));
	lsw_mem_model mem_u (.clk_sys_i(clk_sys_i), .mem_addr_i(addr),
		.mem_rd_i(rd), .mem_wr_i(wr), .mem_wdata_i(wdata),
		.mem_rdata_o(rdata));

	// 100 MHz clock
	always #5 clk_sys_i = ~clk_sys_i;

	task automatic end_of_test();
		if (error_cnt == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test

	// Hang guard, well above the some 600 cycles that all three passes take
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt = error_cnt + 1;
			end_of_test();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk

	// Registers, status and the data area against the reference
	task automatic cmp_all();
		chk(acc, a);
		chk(xr, x);
		chk(yr, y);
		chk(spr, sp);
		chk(psw, f);
		for (int i = 16'h80; i < 16'h300; i++) chk(mem_u.mem[i], m[i]);
	endtask : cmp_all

	// One instruction of the reference; pair wraps inside the page
	task automatic step(input logic [19:0] ent);
		logic [7:0] op, v;
		op = m[pc];
		b1 = m[pc + 16'h1];
		b2 = m[pc + 16'h2];
		ya = {y, a};
		w = {m[8'(b1 + 8'h1)], m[b1]};
		v = 8'h00;
		case (op)
		8'hC4: {a, v} = {b1, b1};
		8'hDB: {a, x, v} = {m[x], x + 8'h1, m[x]};
		8'hC5: {a, v} = {2{m[b1]}};
		8'hD5: {a, v} = {2{m[{b2, b1} + {8'h00, y}]}};
		8'hD4: {a, v} = {2{m[x]}};
		8'hE4: m[b1] = b2;
		8'hE5: m[b1] = a;
		8'hF7: m[w + {8'h00, y}] = a;
		8'hE6: m[8'(b1 + x)] = a;
		8'hF5: m[{b2, b1} + {8'h00, y}] = a;
		8'hFB: {m[x], x} = {a, x + 8'h1};
		8'hEC: m[b1] = x;
		8'hED: m[8'(b1 + y)] = x;
		8'hFC: m[{b2, b1}] = x;
		8'hE9: m[b1] = y;
		8'hF9: m[8'(b1 + x)] = y;
		8'hF8: m[{b2, b1}] = y;
		8'hE8: {x, v} = {a, a};
		8'h9F: {y, v} = {a, a};
		8'hAE: {x, v} = {sp, sp};
		8'hC8: {a, v} = {x, x};
		8'h8E: {sp, v} = {x, x};
		8'hBF: {a, v} = {y, y};
		8'hEE: {a, x} = {x, a};
		8'hDE: {a, y} = {y, a};
		8'hBC: {m[b1], a, v} = {a, m[b1], m[b1]};
		8'hAD: {m[8'(b1 + x)], a, v} = {a, m[8'(b1 + x)], m[8'(b1 + x)]};
		8'hBB: {m[x], a, v} = {a, m[x], m[x]};
		8'hFE: {x, y} = {y, x};
		8'h1D: r = {1'b0, ya} + {1'b0, w};
		8'h3D, 8'h5D: r = {1'b0, ya} - {1'b0, w};
		8'hBD: r = {1'b0, w} - 17'h1;
		8'h9D: r = {1'b0, w} + 17'h1;
		8'h7D: r = {1'b0, w};
		8'hDD: {m[8'(b1 + 8'h1)], m[b1]} = ya;
		8'h1E, 8'h3E: {x, y, v} = op[5] ? {x, b1, b1} : {b1, y, b1};
		8'hCD: {x, v} = {2{m[8'(b1 + y)]}};
		8'hC9: {y, v} = {2{m[b1]}};
		8'hDC: {x, v} = {2{m[{b2, b1}]}};
		default: v = 8'h00;
		endcase
		if (op inside {8'h1D, 8'h3D, 8'h7D}) {y, a} = r[15:0];
		if (op inside {8'h9D, 8'hBD}) {m[8'(b1 + 8'h1)], m[b1]} = r[15:0];
		if (op inside {8'h1D, 8'h3D, 8'h5D, 8'h7D, 8'h9D, 8'hBD}) begin
			f[7] = r[15];
			f[1] = r[15:0] == 16'h0000;
		end
		// Carry after a subtract or compare means no borrow
		if (op inside {8'h1D, 8'h3D, 8'h5D}) f[0] = op == 8'h1D ? r[16] : ya >= w;
		if (op inside {8'h1D, 8'h3D}) begin
			f[6] = (ya[15] ^ r[15]) & ((ya[15] ^ w[15]) == op[5]);
			f[3] = op[5] ? ya[11:0] >= w[11:0] : ya[11:0] + w[11:0] < ya[11:0];
		end
		if (op inside {8'hC4, 8'hDB, 8'hE8, 8'h9F, 8'hAE, 8'hC8, 8'h8E,
			8'hBF, 8'hBC, 8'hAD, 8'hBB, 8'h1E, 8'h3E, 8'hC5, 8'hD5,
			8'hD4, 8'hCD, 8'hC9, 8'hDC}) begin
			f[7] = v[7];
			f[1] = v == 8'h00;
		end
		pc = pc + 16'(ent[7:4]);
	endtask : step

	// Run one instruction and check its length, pulses and results
	task automatic run(input logic [19:0] ent);
		logic uns;
		uns = m[pc] == 8'h00;
		step(ent);
		for (int k = 1; k <= int'(ent[3:0]); k++) begin
			@(posedge clk_sys_i);
			#1;
			if (k == 1) chk(unsup, uns);
			else if (k < int'(ent[3:0])) chk(done, 1'b0);
		end
		chk(done, 1'b1);
		chk(addr, pc);
		chk(pcv, pc);
		chk(rd, 1'b1);
		cmp_all();
	endtask : run

	// Fresh random data and program image, then reset values
	task automatic load();
		logic [7:0] k, o;
		logic [15:0] p;
		p = 16'h0000;
		for (int i = 0; i < 16'h300; i++) m[i] = 8'($urandom);
		m[16'h81] = 8'h01;
		e = 8'h82 + 8'($urandom % 124);
		foreach (PROG[i]) begin
			k = 8'(PROG[i][11:8]);
			o = 8'h82 + 8'($urandom % 124);
			m[p] = PROG[i][19:12];
			m[p + 16'h1] = k == 1 || k == 5 ? 8'($urandom) :
				k == 2 ? {3'b100, 5'($urandom) | 5'h02} : k == 4 ? 8'h40 :
				k == 7 ? 8'h80 : k == 8 ? 8'hFF : k == 9 ? e : o;
			m[p + 16'h2] = k == 6 ? o : 8'h01;
			p = p + 16'(PROG[i][7:4]);
		end
		for (int i = 0; i < 16'h300; i++) mem_u.mem[i] = m[i];
		{a, x, y, sp, f, pc} = {24'h0, 8'hFF, 8'h00, 16'h0000};
	endtask : load

	// Three passes, each entered through a reset; the second and third reset the core after the whole program of the pass before has run
	initial begin
		e = 8'($urandom(17));
		for (int pass = 0; pass < 3; pass++) begin
			@(posedge clk_sys_i);
			rst_n_i <= 1'b0;
			repeat (6) @(posedge clk_sys_i);
			load();
			cmp_all();
			rst_n_i <= 1'b1;
			foreach (PROG[i]) run(PROG[i]);
		end
		end_of_test();
	end
endmodule : test_load_store_transfer_word_ops
